// ### hdl/pbio_port.sv
// Purpose: one 8-bit general purpose port with per-bit mode, driver and threshold
// Assumes: core gives instruction start/end pulses; peripherals give separate outputs, AND-merged here
// Notes: pad drive, pull-up and threshold outputs lag the latches by one cycle
// Function
// - Input mode forces the pin driver to tristate.
// - Input mode samples the pin into the input latch at instruction start.
// - Input mode still copies master into slave latch at instruction end.
// - Three configuration bits select two-way, output, input or alternate output styles.
// - All-ones code on converter pins selects analog input, driver tristate.
// - Output mode drives push-pull or open drain; master echoes to both latches.
// - Two-way drives open drain or weak pull-up; samples pin, updates slave.
// - Data reads of two-way bits return the pin level, not the latch.
// - Alternate output loads slave from peripheral timing, pin still sampled.
// - Alternate output with no peripheral: push-pull high, open drain tristate.
// - Pin input feeds every sharing peripheral; port reads keep working.
// - Converter pin in alternate open-drain code: output forced one, analog passed.
// - Several peripheral outputs on one pin are combined by AND.
// - Alternate input of a pin sees that pin's driven output signal.
// - Wait and clock-stop keep pins; clock outputs stop only in clock-stop.
// - Reset puts pull-up pins in two-way weak pull-up with data all ones.
// - Port writes load master latches always; reads return input latches.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ns
module pbio_port #(
	parameter int WIDTH = 8,
	parameter int N_PERIPH = 2,
	parameter logic [WIDTH-1:0] PULLUP_MASK = 8'hFF,
	parameter logic [WIDTH-1:0] ADC_MASK = 8'h00,
	parameter logic [WIDTH-1:0] CLK_OUT_MASK = 8'h00
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [WIDTH-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [WIDTH-1:0] reg_rdata,
	// Core instruction boundaries and low-power states
	input wire logic instr_start,
	input wire logic instr_end,
	input wire logic wait_for_interrupt_state,
	input wire logic halt_state,
	// Peripheral outputs: value and enable per peripheral per bit, load strobe per bit
	input wire logic [N_PERIPH*WIDTH-1:0] alt_function_output,
	input wire logic [N_PERIPH*WIDTH-1:0] alt_output_enable,
	input wire logic [WIDTH-1:0] alt_output_load,
	// Peripheral inputs
	output logic [WIDTH-1:0] alt_function_input,
	output logic [WIDTH-1:0] adc_analog_en,
	// Pads
	input wire logic [WIDTH-1:0] pad_in,
	output logic [WIDTH-1:0] pad_out,
	output logic [WIDTH-1:0] pad_oe,
	output logic [WIDTH-1:0] pad_pullup_en,
	output logic [WIDTH-1:0] pad_ttl_sel
);

	////////////////////////////////////////////////////////////////////////////
	// Register file: data register holds the output master latches
	logic [WIDTH-1:0] port_data_register_reg;
	logic [WIDTH-1:0] port_cfg_bit_low_reg;
	logic [WIDTH-1:0] port_cfg_bit_mid_reg;
	logic [WIDTH-1:0] port_cfg_bit_high_reg;
	logic [WIDTH-1:0] rdata_next;
	logic wr_data;
	logic wr_low;
	logic wr_mid;
	logic wr_high;

	assign wr_data = reg_wr && (reg_addr == pbio_pkg::ADDR_DATA);
	assign wr_low = reg_wr && (reg_addr == pbio_pkg::ADDR_CFG_LOW);
	assign wr_mid = reg_wr && (reg_addr == pbio_pkg::ADDR_CFG_MID);
	assign wr_high = reg_wr && (reg_addr == pbio_pkg::ADDR_CFG_HIGH);

	// Writes land in the master latches whatever the mode
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			port_data_register_reg <= pbio_pkg::RST_DATA;
			port_cfg_bit_low_reg <= pbio_pkg::RST_CFG;
			port_cfg_bit_mid_reg <= pbio_pkg::RST_CFG;
			port_cfg_bit_high_reg <= pbio_pkg::RST_CFG;
		end else begin
			if (wr_data) port_data_register_reg <= reg_wdata;
			if (wr_low) port_cfg_bit_low_reg <= reg_wdata;
			if (wr_mid) port_cfg_bit_mid_reg <= reg_wdata;
			if (wr_high) port_cfg_bit_high_reg <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-bit decode, peripheral merge and latches
	logic [WIDTH-1:0] slave_vec;
	logic [WIDTH-1:0] in_latch_vec;
	logic [WIDTH-1:0] merged_alt;
	logic [WIDTH-1:0] alt_load_gated;
	logic [WIDTH-1:0] in_mask;
	logic [WIDTH-1:0] out_mask;
	logic [WIDTH-1:0] two_way_mask;
	logic [WIDTH-1:0] alt_mask;
	logic [WIDTH-1:0] analog_mask;
	logic [WIDTH-1:0] pp_mask;
	logic [WIDTH-1:0] cmos_mask;
	logic [WIDTH-1:0] periph_en_any;

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic [2:0] code;
			pbio_pkg::pbio_mode_e mode;
			logic [N_PERIPH-1:0] pv;
			logic [N_PERIPH-1:0] pe;
			assign code = {port_cfg_bit_high_reg[gi], port_cfg_bit_mid_reg[gi],
				port_cfg_bit_low_reg[gi]};
			assign mode = pbio_pkg::pbio_decode(code, ADC_MASK[gi]);
			assign in_mask[gi] = (mode == pbio_pkg::MODE_INPUT);
			assign out_mask[gi] = (mode == pbio_pkg::MODE_OUTPUT);
			assign two_way_mask[gi] = (mode == pbio_pkg::MODE_TWO_WAY);
			assign alt_mask[gi] = (mode == pbio_pkg::MODE_ALT_OUT);
			assign analog_mask[gi] = (mode == pbio_pkg::MODE_ANALOG);
			assign pp_mask[gi] = pbio_pkg::pbio_push_pull(code);
			assign cmos_mask[gi] = (code == pbio_pkg::CODE_IN_CMOS);
			// Disabled or absent peripherals count as one, so none connected reads high
			for (genvar p = 0; p < N_PERIPH; p++) begin : g_per
				assign pv[p] = alt_function_output[p*WIDTH+gi];
				assign pe[p] = alt_output_enable[p*WIDTH+gi];
			end
			assign merged_alt[gi] = &(pv | ~pe);
			assign periph_en_any[gi] = |pe; // Any peripheral claims this bit
			// Clock outputs freeze in clock-stop, keep running in wait
			assign alt_load_gated[gi] = alt_output_load[gi] &&
				!(halt_state && CLK_OUT_MASK[gi]);

			pbio_bit_slice u_slice (
				.sys_clk(sys_clk),
				.rstn(rstn),
				.mode(mode),
				.master(port_data_register_reg[gi]),
				.pad_level(pad_in[gi]),
				.instr_start(instr_start),
				.instr_end(instr_end),
				.alt_val(merged_alt[gi]),
				.alt_load(alt_load_gated[gi]),
				.slave_reg(slave_vec[gi]),
				.in_latch_reg(in_latch_vec[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Pad drive decode: push-pull drives both levels, open drain only pulls low
	logic [WIDTH-1:0] drive_mask;
	logic [WIDTH-1:0] oe_next;
	logic [WIDTH-1:0] out_next;
	logic [WIDTH-1:0] pullup_next;
	logic [WIDTH-1:0] driven_level;
	logic [WIDTH-1:0] alt_in_next;

	assign drive_mask = out_mask | two_way_mask | alt_mask;
	assign oe_next = drive_mask & (pp_mask | ~slave_vec);
	assign out_next = drive_mask & pp_mask & slave_vec;
	assign pullup_next = two_way_mask & PULLUP_MASK & ~pp_mask &
		~port_cfg_bit_high_reg;
	// What the pin carries when this bit drives it, open drain wired with the pad
	assign driven_level = (pp_mask & slave_vec) | (~pp_mask & slave_vec & pad_in);
	// Alternate inputs see the pin; in alternate output mode that is our own drive
	assign alt_in_next = (alt_mask & driven_level) | (~alt_mask & pad_in);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pad_oe <= '0;
			pad_out <= '0;
			pad_pullup_en <= PULLUP_MASK;
			pad_ttl_sel <= '1;
			adc_analog_en <= '0;
			alt_function_input <= '0;
		end else begin
			pad_oe <= oe_next;
			pad_out <= out_next;
			pad_pullup_en <= pullup_next;
			pad_ttl_sel <= ~cmos_mask;
			adc_analog_en <= analog_mask;
			alt_function_input <= alt_in_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data: present only in the cycle after the read strobe
	always_comb begin
		rdata_next = '0;
		if (reg_addr == pbio_pkg::ADDR_DATA) begin
			rdata_next = in_latch_vec;
		end else if (reg_addr == pbio_pkg::ADDR_CFG_LOW) begin
			rdata_next = port_cfg_bit_low_reg;
		end else if (reg_addr == pbio_pkg::ADDR_CFG_MID) begin
			rdata_next = port_cfg_bit_mid_reg;
		end else begin
			rdata_next = port_cfg_bit_high_reg;
		end
	end

	// A read of two-way bits sees pins, so read-modify-write can lose bits
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	chk_input_tristate: assert property (
		1'b1 |=> ((pad_oe & $past(in_mask)) == '0))
		else $error("input bit drives its pad");

	chk_pin_sampled: assert property (
		instr_start |=> (((in_latch_vec ^ $past(pad_in)) & $past(~out_mask)) == '0))
		else $error("input latch missed pin sample");

	chk_slave_follows: assert property (
		instr_end |=> (((slave_vec ^ $past(port_data_register_reg)) &
			$past(in_mask | out_mask | two_way_mask)) == '0))
		else $error("slave latch not loaded from master");

	chk_output_echo: assert property (
		instr_end && !instr_start |=> (((in_latch_vec ^ $past(port_data_register_reg)) &
			$past(out_mask)) == '0))
		else $error("output mode input latch not echoed");

	chk_push_pull: assert property (
		1'b1 |=> (((~pad_oe | (pad_out ^ $past(slave_vec))) & $past(pp_mask & drive_mask))
			== '0))
		else $error("push-pull drive wrong");

	chk_open_drain: assert property (
		1'b1 |=> (((pad_out | (pad_oe ^ ~$past(slave_vec))) &
			$past(~pp_mask & drive_mask)) == '0))
		else $error("open drain drive wrong");

	chk_read_data: assert property (
		reg_rd && reg_addr == pbio_pkg::ADDR_DATA |=> reg_rdata == $past(in_latch_vec))
		else $error("data read not from input latch");

	chk_write_master: assert property (
		wr_data |=> port_data_register_reg == $past(reg_wdata))
		else $error("write did not reach master");

	chk_analog_hiz: assert property (
		1'b1 |=> ((pad_oe & $past(analog_mask)) == '0) &&
			(adc_analog_en == $past(analog_mask)))
		else $error("analog pin not released");

	chk_alt_merge: assert property (
		1'b1 |=> (((slave_vec ^ $past(merged_alt)) & $past(alt_mask & alt_load_gated))
			== '0))
		else $error("merged peripheral output not loaded");

	chk_halt_clock: assert property (
		halt_state |=> (((slave_vec ^ $past(slave_vec)) & CLK_OUT_MASK &
			$past(alt_mask)) == '0))
		else $error("clock output moved in clock-stop");

	chk_weak_pullup: assert property (
		1'b1 |=> pad_pullup_en == $past(PULLUP_MASK & ~port_cfg_bit_high_reg &
			~port_cfg_bit_mid_reg & ~port_cfg_bit_low_reg))
		else $error("pull-up enable wrong");

	////////////////////////////////////////////////////////////////////////////
	// Second group: alternate path, pin views, instruction boundaries, low-power states and register port
	// A broken gate here would only show on mixed-mode ports, so each check but the two register port ones is per bit

	// Peripheral load path
	chk_no_periph_high: assert property (
		1'b1 |=> ((~slave_vec & $past(alt_mask & alt_load_gated & ~periph_en_any)) == '0))
		else $error("idle alternate bit not high");

	chk_analog_forced: assert property (
		1'b1 |=> ((~slave_vec & $past(analog_mask)) == '0))
		else $error("analog bit output not forced high");

	chk_alt_ignores_end: assert property (
		instr_end |=> (((slave_vec ^ $past(slave_vec)) &
			$past(alt_mask & ~alt_load_gated)) == '0))
		else $error("instruction end moved alternate slave");

	// Pin views seen by the peripherals, threshold select and quiet drive of released bits
	chk_alt_input_view: assert property (
		1'b1 |=> (((alt_function_input ^ $past(slave_vec)) &
			$past(alt_mask & pp_mask)) == '0))
		else $error("alternate input misses own drive");

	chk_shared_input: assert property (
		1'b1 |=> (((alt_function_input ^ $past(pad_in)) & $past(~alt_mask)) == '0))
		else $error("alternate input misses pin");

	chk_ttl_select: assert property (
		1'b1 |=> pad_ttl_sel == $past(port_cfg_bit_high_reg | port_cfg_bit_mid_reg |
			~port_cfg_bit_low_reg))
		else $error("threshold select wrong");

	chk_input_quiet: assert property (
		1'b1 |=> ((pad_out & $past(in_mask | analog_mask)) == '0))
		else $error("released bit shows drive value");

	// Instruction boundaries
	chk_output_no_sample: assert property (
		instr_start && !instr_end |=> (((in_latch_vec ^ $past(in_latch_vec)) &
			$past(out_mask)) == '0))
		else $error("output bit sampled its pin");

	chk_start_keeps_slave: assert property (
		instr_start && !instr_end |=> (((slave_vec ^ $past(slave_vec)) &
			$past(~alt_mask & ~analog_mask)) == '0))
		else $error("instruction start moved slave latch");

	// Low-power states: wait keeps every load, clock-stop only blocks clock bits
	chk_wait_loads: assert property (
		wait_for_interrupt_state && !halt_state |=> (((slave_vec ^ $past(merged_alt)) &
			$past(alt_mask & alt_output_load)) == '0))
		else $error("load lost in wait state");

	chk_halt_other_bits: assert property (
		halt_state |=> (((slave_vec ^ $past(merged_alt)) &
			$past(alt_mask & alt_output_load & ~CLK_OUT_MASK)) == '0))
		else $error("non-clock load lost in clock-stop");

	// Register port
	chk_read_idle: assert property (
		!reg_rd |=> reg_rdata == '0)
		else $error("read data outside read cycle");

	chk_config_readback: assert property (
		reg_rd && reg_addr == pbio_pkg::ADDR_CFG_LOW |=>
			reg_rdata == $past(port_cfg_bit_low_reg))
		else $error("low configuration read wrong");

	cov_output_write: cover property (wr_data ##1 instr_end ##1 (|(pad_oe & out_mask)));
	cov_halt_hold: cover property (halt_state && (|(alt_mask & alt_output_load & CLK_OUT_MASK)));
	cov_two_way_read: cover property ((|two_way_mask) && reg_rd &&
		reg_addr == pbio_pkg::ADDR_DATA);
	cov_alt_load: cover property (|(alt_mask & alt_load_gated));
	cov_wait_run: cover property (wait_for_interrupt_state && (|alt_load_gated));

endmodule

// ### hdl/pbio_pkg.sv
// Purpose: shared constants, mode type and decode helpers for the port bit I/O block
// Assumes: one 8-bit port, three configuration registers and one data register
// Notes: configuration code is written {high, mid, low}
package pbio_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets on the plain register port
	localparam logic [1:0] ADDR_DATA = 2'h0;
	localparam logic [1:0] ADDR_CFG_LOW = 2'h1;
	localparam logic [1:0] ADDR_CFG_MID = 2'h2;
	localparam logic [1:0] ADDR_CFG_HIGH = 2'h3;

	// Reset values: two-way weak pull-up with all data ones
	localparam logic [7:0] RST_DATA = 8'hFF;
	localparam logic [7:0] RST_CFG = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Configuration codes {high, mid, low}
	localparam logic [2:0] CODE_TWO_WAY_WP = 3'h0;
	localparam logic [2:0] CODE_TWO_WAY_OD = 3'h4;
	localparam logic [2:0] CODE_OUT_PP = 3'h2;
	localparam logic [2:0] CODE_OUT_OD = 3'h6;
	localparam logic [2:0] CODE_IN_CMOS = 3'h1;
	localparam logic [2:0] CODE_IN_TTL = 3'h5;
	localparam logic [2:0] CODE_ALT_PP = 3'h3;
	localparam logic [2:0] CODE_ALT_OD = 3'h7;

	// Operating mode of one bit, one-hot
	typedef enum logic [4:0] {
		MODE_TWO_WAY = 5'h01,
		MODE_OUTPUT = 5'h02,
		MODE_INPUT = 5'h04,
		MODE_ALT_OUT = 5'h08,
		MODE_ANALOG = 5'h10
	} pbio_mode_e;

	////////////////////////////////////////////////////////////////////////////
	// Decode a code into a mode; the all-ones code is analog on converter pins
	function automatic pbio_mode_e pbio_decode(input logic [2:0] code, input logic is_adc);
		pbio_mode_e m;
		m = MODE_TWO_WAY;
		if (code == CODE_ALT_OD && is_adc) begin
			m = MODE_ANALOG;
		end else if (code == CODE_OUT_PP || code == CODE_OUT_OD) begin
			m = MODE_OUTPUT;
		end else if (code == CODE_IN_CMOS || code == CODE_IN_TTL) begin
			m = MODE_INPUT;
		end else if (code == CODE_ALT_PP || code == CODE_ALT_OD) begin
			m = MODE_ALT_OUT;
		end
		return m;
	endfunction

	// Push-pull driver codes; every other driving code is open drain
	function automatic logic pbio_push_pull(input logic [2:0] code);
		return (code == CODE_OUT_PP) || (code == CODE_ALT_PP);
	endfunction

endpackage

// ### hdl/pbio_bit_slice.sv
// Purpose: latches of one port bit: output slave latch and input latch
// Assumes: instruction start and end arrive as one-cycle pulses
// Notes: the output master latch lives in the data register of the top
`timescale 1ns/1ns
module pbio_bit_slice (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Configuration and data
	input wire pbio_pkg::pbio_mode_e mode,
	input wire logic master,
	input wire logic pad_level,
	// Instruction boundaries
	input wire logic instr_start,
	input wire logic instr_end,
	// Merged peripheral output and its load strobe
	input wire logic alt_val,
	input wire logic alt_load,
	// Latch contents
	output logic slave_reg,
	output logic in_latch_reg
);

	////////////////////////////////////////////////////////////////////////////
	// Input latch: pin sampled at start, master echoed at end in output mode
	logic samples_pin;
	logic echoes_master;
	assign samples_pin = instr_start && (mode != pbio_pkg::MODE_OUTPUT);
	assign echoes_master = instr_end && (mode == pbio_pkg::MODE_OUTPUT);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			in_latch_reg <= 1'b1;
		end else if (samples_pin) begin
			in_latch_reg <= pad_level;
		end else if (echoes_master) begin
			in_latch_reg <= master;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Slave latch: peripheral-timed in alternate mode, forced high for analog
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			slave_reg <= 1'b1;
		end else if (mode == pbio_pkg::MODE_ANALOG) begin
			slave_reg <= 1'b1;
		end else if (mode == pbio_pkg::MODE_ALT_OUT) begin
			if (alt_load) begin
				slave_reg <= alt_val;
			end
		end else if (instr_end) begin
			slave_reg <= master;
		end
	end

endmodule

// ### tb/pbio_pin_model.sv
// Purpose: circuitry on the port pads, resolving each pad level
// Assumes: the bench commands an external driver per pad
// Notes: a floating pad without pull-up toggles so stale levels never pass
`timescale 1ns/1ns
module pbio_pin_model (
	// Clock
	input wire logic sys_clk,
	// Port drivers
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pad_pullup_en,
	// External driver
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	// Resolved level
	output logic [7:0] pad_in
);
	logic [7:0] float_reg = 8'h5A;

	////////////////////////////////////////////////////////////////////////////
	// Floating pattern, new every cycle
	always @(posedge sys_clk) begin
		float_reg <= ~float_reg;
	end

	// Port sink or source wins, then the external driver, then the pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_val[i];
			else if (pad_pullup_en[i])
				pad_in[i] = 1'b1;
			else
				pad_in[i] = float_reg[i];
		end
	end
endmodule

// ### tb/tb_pbio_port.sv
// Purpose: self-checking bench of the 8-bit port
// Assumes: pull-ups on bits 0-5, converter on bits 4-7
// Notes: pads are checked after the one-cycle lag behind the latches
`timescale 1ns/1ns
module tb_pbio_port;
	localparam logic [7:0] PU = 8'h3F;
	localparam logic [7:0] ADC = 8'hF0;
	localparam logic [7:0] CK = 8'h01;
	logic sys_clk, rstn, reg_wr, reg_rd, instr_start, instr_end, wait_for_interrupt_state, halt;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, alt_output_load, alt_function_input, adc_analog_en;
	logic [15:0] alt_function_output, alt_output_enable;
	logic [7:0] pad_in, pad_out, pad_oe, pad_pullup_en, pad_ttl_sel, ext_en, ext_val;
	logic [7:0] d, e, r, s, pin, x, hold;
	logic [31:0] p;
	int seed, miscompares, total_checks, cycles;

	pbio_port #(.PULLUP_MASK(PU), .ADC_MASK(ADC), .CLK_OUT_MASK(CK)) pbio_port_i (
		.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr_start,
		.instr_end, .wait_for_interrupt_state, .halt_state(halt), .alt_function_output,
		.alt_output_enable, .alt_output_load, .alt_function_input, .adc_analog_en,
		.pad_in, .pad_out, .pad_oe, .pad_pullup_en, .pad_ttl_sel);
	pbio_pin_model pbio_pin_model_i (.sys_clk, .pad_out, .pad_oe, .pad_pullup_en, .ext_en,
		.ext_val, .pad_in);

	////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			close_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Comparison, bus cycles and pulses
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task setcfg(input logic [2:0] c);
		wr(pbio_pkg::ADDR_CFG_LOW, {8{c[0]}});
		wr(pbio_pkg::ADDR_CFG_MID, {8{c[1]}});
		wr(pbio_pkg::ADDR_CFG_HIGH, {8{c[2]}});
	endtask
	task pulse(input logic st);
		@(posedge sys_clk);
		instr_start <= st;
		instr_end <= ~st;
		@(posedge sys_clk);
		instr_start <= 1'b0;
		instr_end <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Expected {oe, out, pull-up, ttl} for a code with slave latches s
	function automatic logic [31:0] pads(input logic [2:0] c, input logic [7:0] s);
		case (c)
			3'h0: return {~s, 8'h00, PU, 8'hFF};
			3'h2, 3'h3: return {8'hFF, s, 8'h00, 8'hFF};
			3'h1: return 32'h0000_0000;
			3'h5: return 32'h0000_00FF;
			default: return {~s, 8'h00, 8'h00, 8'hFF};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 24895;
		{rstn, reg_wr, reg_rd, instr_start, instr_end, wait_for_interrupt_state, halt} = '0;
		{reg_addr, reg_wdata, alt_output_load, alt_function_output, alt_output_enable} = '0;
		{ext_en, ext_val, miscompares, total_checks, cycles} = '0;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		#1;
		// State out of reset
		chk(pad_oe, 8'h00);
		chk(pad_pullup_en, PU);
		for (int a = 0; a < 4; a++) begin
			rd(a[1:0], r);
			chk(r, a == 0 ? 8'hFF : 8'h00);
		end
		setcfg(3'h2);
		pulse(1'b0);
		chk(pad_out, 8'hFF);
		// Input mode still moves master into slave
		p = $random(seed);
		d = p[7:0];
		setcfg(3'h1);
		wr(pbio_pkg::ADDR_DATA, d);
		pulse(1'b0);
		setcfg(3'h2);
		repeat (2) @(posedge sys_clk);
		#1;
		chk(pad_out, d);
		// Every code, pins driven from outside where the port lets go
		for (int k = 0; k < 8; k++) begin
			p = $random(seed);
			d = p[7:0];
			e = p[15:8];
			ext_en <= 8'hFF;
			ext_val <= e;
			wr(pbio_pkg::ADDR_DATA, d);
			setcfg(k[2:0]);
			@(posedge sys_clk);
			alt_output_load <= 8'hFF;
			alt_output_enable <= 16'h0000;
			@(posedge sys_clk);
			alt_output_load <= 8'h00;
			pulse(1'b0);
			s = (k == 3 || k == 7) ? 8'hFF : d;
			p = pads(k[2:0], s);
			pin = (p[31:24] & p[23:16]) | (~p[31:24] & e);
			chk(pad_oe, p[31:24]);
			chk(pad_out & p[31:24], p[23:16]);
			chk(pad_pullup_en, p[15:8]);
			chk(pad_ttl_sel, p[7:0]);
			chk(adc_analog_en, k == 7 ? ADC : 8'h00);
			chk(alt_function_input, pin);
			pulse(1'b1);
			rd(pbio_pkg::ADDR_DATA, r);
			chk(r, (k == 2 || k == 6) ? d : pin);
		end
		// Peripheral outputs merged onto push-pull alternate pins; bit 0 is a clock output
		ext_en <= 8'h00;
		setcfg(3'h3);
		x = 8'hFF;
		for (int k = 0; k < 30; k++) begin
			@(posedge sys_clk);
			p = $random(seed);
			alt_function_output <= p[15:0];
			alt_output_enable <= p[31:16];
			p = $random(seed);
			wait_for_interrupt_state <= p[0];
			halt <= p[1];
			alt_output_load <= 8'hFF;
			@(posedge sys_clk);
			alt_output_load <= 8'h00;
			repeat (2) @(posedge sys_clk);
			#1;
			// Clock bits keep their last level while the core clock is stopped
			hold = CK & {8{halt}};
			x = (x & hold) | (~hold & (alt_function_output[7:0] | ~alt_output_enable[7:0]) &
				(alt_function_output[15:8] | ~alt_output_enable[15:8]));
			chk(pad_out, x);
			chk(alt_function_input, x);
		end
		// Instruction end leaves alternate slaves alone
		wr(pbio_pkg::ADDR_DATA, ~x);
		pulse(1'b0);
		chk(pad_out, x);
		close_out;
	end
endmodule
